// ### design/e1_perf_cfg.svh
/*
  Offsets, counter widths, reset values and timing figures for the E1 performance monitor.
  Assumes inclusion by its bare name from the package and the error counter module.
*/
`ifndef E1_PERF_CFG_SVH
`define E1_PERF_CFG_SVH

// register offsets on the parallel port
`define OFS_VIOL_HIGH 8'h00
`define OFS_VIOL_LOW 8'h01
`define OFS_CRC_FAS_HIGH 8'h02
`define OFS_CRC_LOW 8'h03
`define OFS_EBIT_FAS 8'h04
`define OFS_EBIT_LOW 8'h05
`define OFS_IRQ_MASK 8'h17

// reset values
`define MASK_RESET 8'h00
`define READ_IDLE 8'h00

// counter widths
`define VIOL_W 16
`define CRC_W 10
`define EBIT_W 10
`define ALIGN_W 12

// interval timing, in ns, and the clock period
`define CLK_PERIOD_NS 10
`define LONG_INTERVAL_NS 1000000000
`define SHORT_INTERVAL_NS 62500000

`endif

// ### design/e1_perf_pkg.sv
/*
  Types shared by the E1 performance monitor modules.
  Assumes e1_perf_cfg.svh is on the include path.
*/
package e1_perf_pkg;
  `include "e1_perf_cfg.svh"

  // error events from the receive framer and decoder, one cycle each
  typedef struct packed {
    logic pulse_pos;
    logic pulse_neg;
    logic hdb3_subst;
    logic crc_error;
    logic ebit_seen;
    logic ebit_value;
    logic align_error;
  } line_events_s;

  // receive sync state, levels
  typedef struct packed {
    logic receive_sync_loss;
    logic fas_search;
    logic cas_search;
    logic crc_search;
  } sync_state_s;

  // ctrl_one and ctrl_two bits that steer this block
  typedef struct packed {
    logic period_short;
    logic count_code_viol;
    logic hdb3_enable;
  } perf_ctrl_s;

  typedef enum logic [1:0] {
    POL_NONE,
    POL_POS,
    POL_NEG
  } polarity_e;
endpackage : e1_perf_pkg

// ### design/sat_counter.sv
/*
  Saturating event counter with restart on interval boundary.
  Assumes a one-cycle count pulse and a one-cycle restart strobe on the same clock.
*/
`timescale 1ns/1ns
module sat_counter #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control
  input wire logic i_count,
  input wire logic i_restart,
  // value
  output logic [WIDTH-1:0] o_value
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (i_restart) begin
      // the boundary event itself opens the new interval
      nxt_count = i_count ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
    end else if (i_count && (count_ff != {WIDTH{1'b1}})) begin
      nxt_count = count_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign o_value = count_ff;
endmodule : sat_counter

// ### design/e1_error_counters_irq_mask.sv
/*
  E1 error counters, interval latches and status_two interrupt mask for one framer.
  Assumes line events and sync state come from the receive framer on i_clock
  (the recovered line clock); the host port signals are already synchronous.
*/
// How it works
// - eight-bit mask enables status_two interrupts
// - counts latch each one-second or 62.5 ms interval
// - counters saturate, never wrap
// - violation count high at 0x00, low at 0x01
// - mode 0 counts bipolar violations
// - hdb3 substitution violations not counted when hdb3 enabled
// - mode 1 counts code violations
// - violations counted always, saturate at 65535
// - crc count bits split across 0x02/0x03
// - crc and ebit halt on fas/crc loss
// - count received ebit zeros in multiframe
// - ebit count bits split across 0x04/0x05
// - align count upper six bits of 0x02/0x04
// - align count halts on sync loss/search
// - interval flag once per second or 62.5 ms
`timescale 1ns/1ns
`include "e1_perf_cfg.svh"
module e1_error_counters_irq_mask #(
  parameter int LONG_CYCLES = `LONG_INTERVAL_NS / `CLK_PERIOD_NS,
  parameter int SHORT_CYCLES = `SHORT_INTERVAL_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // receive framer side
  input wire e1_perf_pkg::line_events_s i_events,
  input wire e1_perf_pkg::sync_state_s i_sync,
  input wire e1_perf_pkg::perf_ctrl_s i_ctrl,
  // host port
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // status
  output logic o_interval_timer_flag,
  output logic [7:0] o_status_two_irq_mask
);
  localparam int TW = $clog2(LONG_CYCLES + 1);

  logic [TW-1:0] timer_ff;
  logic [TW-1:0] nxt_timer;
  logic tick_ff;
  logic nxt_tick;
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  e1_perf_pkg::polarity_e last_pol_ff;
  e1_perf_pkg::polarity_e nxt_last_pol;
  e1_perf_pkg::polarity_e last_bpv_ff;
  e1_perf_pkg::polarity_e nxt_last_bpv;
  logic [`VIOL_W-1:0] viol_lat_ff;
  logic [`VIOL_W-1:0] nxt_viol_lat;
  logic [`CRC_W-1:0] crc_lat_ff;
  logic [`CRC_W-1:0] nxt_crc_lat;
  logic [`EBIT_W-1:0] ebit_lat_ff;
  logic [`EBIT_W-1:0] nxt_ebit_lat;
  logic [`ALIGN_W-1:0] align_lat_ff;
  logic [`ALIGN_W-1:0] nxt_align_lat;

  logic [`VIOL_W-1:0] viol_run;
  logic [`CRC_W-1:0] crc_run;
  logic [`EBIT_W-1:0] ebit_run;
  logic [`ALIGN_W-1:0] align_run;
  logic viol_inc;
  logic crc_inc;
  logic ebit_inc;
  logic align_inc;
  logic mark;
  e1_perf_pkg::polarity_e mark_pol;
  logic bpv;

  // polarity match, shared by the bipolar and code violation tests
  function automatic logic same_pol(input e1_perf_pkg::polarity_e a,
      input e1_perf_pkg::polarity_e b);
    same_pol = (a != e1_perf_pkg::POL_NONE) && (a == b);
  endfunction : same_pol

  // crc and ebit share one halt; cas loss alone leaves them running
  function automatic logic mf_counting(input e1_perf_pkg::sync_state_s s);
    mf_counting = !s.fas_search && !s.crc_search;
  endfunction : mf_counting

  // alignment errors need the framer settled on every level
  function automatic logic align_counting(input e1_perf_pkg::sync_state_s s);
    align_counting = !s.receive_sync_loss && mf_counting(s) && !s.cas_search;
  endfunction : align_counting

  // shared bytes: six bits of one count above two bits of another
  function automatic logic [7:0] join_bytes(input logic [5:0] up, input logic [1:0] lo);
    join_bytes = {up, lo};
  endfunction : join_bytes

  // interval timer
  always_comb begin
    nxt_tick = 1'b0;
    nxt_timer = timer_ff + 1'b1;
    if (timer_ff >= TW'(i_ctrl.period_short ? SHORT_CYCLES - 1 : LONG_CYCLES - 1)) begin
      nxt_timer = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timer_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      timer_ff <= nxt_timer;
      tick_ff <= nxt_tick;
    end
  end

  // violation detection
  always_comb begin
    mark = i_events.pulse_pos | i_events.pulse_neg;
    mark_pol = i_events.pulse_pos ? e1_perf_pkg::POL_POS : e1_perf_pkg::POL_NEG;
    // two marks in a row with the same polarity
    bpv = mark && same_pol(last_pol_ff, mark_pol);
    nxt_last_pol = mark ? mark_pol : last_pol_ff;
    nxt_last_bpv = last_bpv_ff;
    viol_inc = 1'b0;
    if (!i_ctrl.count_code_viol) begin
      // substitution violations are intentional
      viol_inc = bpv && !(i_ctrl.hdb3_enable && i_events.hdb3_subst);
    end else if (bpv) begin
      // code violation: this violation has the polarity of the previous one
      viol_inc = same_pol(last_bpv_ff, mark_pol);
      nxt_last_bpv = mark_pol;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      last_pol_ff <= e1_perf_pkg::POL_NONE;
      last_bpv_ff <= e1_perf_pkg::POL_NONE;
    end else begin
      last_pol_ff <= nxt_last_pol;
      last_bpv_ff <= nxt_last_bpv;
    end
  end

  // counting qualifiers
  always_comb begin
    // violations ignore sync state
    crc_inc = i_events.crc_error && mf_counting(i_sync);
    ebit_inc = i_events.ebit_seen && !i_events.ebit_value
      && mf_counting(i_sync);
    align_inc = i_events.align_error && align_counting(i_sync);
  end

  // running counters, saturating, restarted at each boundary
  sat_counter #(.WIDTH(`VIOL_W)) u_viol (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_count(viol_inc),
    .i_restart(tick_ff),
    .o_value(viol_run)
  );

  sat_counter #(.WIDTH(`CRC_W)) u_crc (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_count(crc_inc),
    .i_restart(tick_ff),
    .o_value(crc_run)
  );

  sat_counter #(.WIDTH(`EBIT_W)) u_ebit (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_count(ebit_inc),
    .i_restart(tick_ff),
    .o_value(ebit_run)
  );

  sat_counter #(.WIDTH(`ALIGN_W)) u_align (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_count(align_inc),
    .i_restart(tick_ff),
    .o_value(align_run)
  );

  // latches: host sees the previous interval; overwritten at the next one
  always_comb begin
    nxt_viol_lat = viol_lat_ff;
    nxt_crc_lat = crc_lat_ff;
    nxt_ebit_lat = ebit_lat_ff;
    nxt_align_lat = align_lat_ff;
    if (tick_ff) begin
      nxt_viol_lat = viol_run;
      nxt_crc_lat = crc_run;
      nxt_ebit_lat = ebit_run;
      nxt_align_lat = align_run;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      viol_lat_ff <= '0;
      crc_lat_ff <= '0;
      ebit_lat_ff <= '0;
      align_lat_ff <= '0;
    end else begin
      viol_lat_ff <= nxt_viol_lat;
      crc_lat_ff <= nxt_crc_lat;
      ebit_lat_ff <= nxt_ebit_lat;
      align_lat_ff <= nxt_align_lat;
    end
  end

  // host port: mask write, registered read data
  always_comb begin
    nxt_mask = mask_ff;
    if (i_wr && (i_addr == `OFS_IRQ_MASK)) begin
      nxt_mask = i_wdata;
    end
    nxt_rdata = `READ_IDLE;
    if (i_rd) begin
      unique case (i_addr)
        `OFS_VIOL_HIGH: nxt_rdata = viol_lat_ff[15:8];
        `OFS_VIOL_LOW: nxt_rdata = viol_lat_ff[7:0];
        `OFS_CRC_FAS_HIGH: nxt_rdata = join_bytes(align_lat_ff[11:6], crc_lat_ff[9:8]);
        `OFS_CRC_LOW: nxt_rdata = crc_lat_ff[7:0];
        `OFS_EBIT_FAS: nxt_rdata = join_bytes(align_lat_ff[5:0], ebit_lat_ff[9:8]);
        `OFS_EBIT_LOW: nxt_rdata = ebit_lat_ff[7:0];
        `OFS_IRQ_MASK: nxt_rdata = mask_ff;
        default: nxt_rdata = `READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mask_ff <= `MASK_RESET;
      rdata_ff <= `READ_IDLE;
    end else begin
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_interval_timer_flag = tick_ff;
  assign o_status_two_irq_mask = mask_ff;
endmodule : e1_error_counters_irq_mask

// ### verification/e1_perf_chk.sv
/*
  Host port and interval timer checks for the E1 error counters.
  Assumes binding into the monitor top; sees only its ports.
*/
`timescale 1ns/1ns
module e1_perf_chk #(
  parameter int LONG_CYCLES = 200,
  parameter int SHORT_CYCLES = 50
) (
  // clock, reset, control
  input wire logic i_clock,
  input wire logic i_rst,
  input wire e1_perf_pkg::perf_ctrl_s i_ctrl,
  // host port and outputs
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_interval_timer_flag,
  input wire logic [7:0] o_status_two_irq_mask
);
  int gap_ff, nxt_gap, lim;
  logic seen_ff, nxt_seen, flg, mwr;
  assign flg = o_interval_timer_flag;
  assign mwr = i_wr && i_addr == 8'h17;
  // first interval after reset is not judged, its start is loosely defined
  always_comb begin
    lim = i_ctrl.period_short ? SHORT_CYCLES : LONG_CYCLES;
    nxt_gap = flg ? 0 : gap_ff + 1;
    nxt_seen = seen_ff | flg;
  end
  always_ff @(posedge i_clock) begin
    gap_ff <= i_rst ? 0 : nxt_gap;
    seen_ff <= i_rst ? 1'b0 : nxt_seen;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_MASK_WR: assert property (mwr |=> o_status_two_irq_mask == $past(i_wdata))
    else $error("mask write lost");
  AST_MASK_HOLD: assert property (!mwr |=> $stable(o_status_two_irq_mask))
    else $error("mask changed");
  AST_MASK_RD: assert property (i_rd && !i_wr && i_addr == 8'h17
    |=> o_rdata == $past(o_status_two_irq_mask)) else $error("mask read");
  AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("idle read data");
  AST_UNMAPPED: assert property (i_rd && !(i_addr inside {[8'h00:8'h05], 8'h17})
    |=> o_rdata == 8'h00) else $error("unmapped read");
  AST_FLAG_PULSE: assert property (flg |=> !flg)
    else $error("flag too long");
  AST_FLAG_PERIOD: assert property (flg && seen_ff |-> gap_ff == lim - 1)
    else $error("interval length");
  AST_FLAG_DUE: assert property (seen_ff |-> gap_ff < lim)
    else $error("interval overdue");
endmodule : e1_perf_chk
bind e1_error_counters_irq_mask e1_perf_chk #(.LONG_CYCLES(LONG_CYCLES),
  .SHORT_CYCLES(SHORT_CYCLES)) u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_ctrl(i_ctrl),
  .i_rd(i_rd), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_interval_timer_flag(o_interval_timer_flag),
  .o_status_two_irq_mask(o_status_two_irq_mask));

// ### verification/host_model.sv
/*
  Host on the parallel port, one byte transfer at a time.
  Assumes the caller reads right after the interval flag.
*/
`timescale 1ns/1ns
module host_model (
  // clock and read data
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  // strobes, address, write data
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'hFF;
    o_wdata = 8'hFF;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] rd);
    @(negedge i_clock);
    o_rd = !wr;
    o_wr = wr;
    o_addr = a;
    o_wdata = wd;
    @(negedge i_clock);
    rd = i_rdata;
    o_rd = 1'b0;
    o_wr = 1'b0;
    // released lines flip, a stale value never looks held
    o_addr = ~a;
    o_wdata = ~wd;
  endtask : xfer
endmodule : host_model

// ### verification/tb.sv
/*
  Self-checking bench for the E1 error counters and mask.
  Assumes host_model on the port; events change at the falling edge.
*/
`timescale 1ns/1ns
module tb;
  localparam int LONG_N = 70000;
  localparam int SHORT_N = 50;
  logic i_clock, i_rst, rd, wr, flag;
  logic [7:0] addr, wdata, rdata, mask;
  e1_perf_pkg::line_events_s ev;
  e1_perf_pkg::sync_state_s sy;
  e1_perf_pkg::perf_ctrl_s ct;
  int err_count, checked;
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  host_model host (.i_clock(i_clock), .i_rdata(rdata), .o_rd(rd), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata));
  e1_error_counters_irq_mask #(.LONG_CYCLES(LONG_N), .SHORT_CYCLES(SHORT_N)) DUT (
    .i_clock(i_clock), .i_rst(i_rst), .i_events(ev), .i_sync(sy), .i_ctrl(ct),
    .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_interval_timer_flag(flag), .o_status_two_irq_mask(mask));
  task automatic tally_and_finish();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.xfer(1'b0, a, 8'h00, d);
    chk8("read data", exp, d);
  endtask : rd_chk
  task automatic read_six(input logic [47:0] exp);
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(i), exp[47-8*i -: 8]);
    end
  endtask : read_six
  task automatic restart(input logic [2:0] c);
    ct = c;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
  endtask : restart
  // entries are {events, sync}, one cycle each
  task automatic play(input logic [10:0] seq[$]);
    foreach (seq[i]) begin
      ev = seq[i][10:4];
      sy = seq[i][3:0];
      @(negedge i_clock);
    end
    ev = '0;
    sy = '0;
  endtask : play
  task automatic wait_flag(input int limit);
    for (int n = 0; flag !== 1'b1; n++) begin
      if (n == limit) begin
        chk8("interval flag", 8'h01, {7'h00, flag});
        tally_and_finish();
      end
      @(negedge i_clock);
    end
  endtask : wait_flag
  task automatic t_mask();
    logic [7:0] d;
    restart(3'h4);
    rd_chk(8'h17, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b1, 8'h17, 8'h01 << i, d);
      chk8("mask pins", 8'h01 << i, mask);
      rd_chk(8'h17, 8'h01 << i);
    end
    host.xfer(1'b1, 8'h01, 8'h5A, d);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h17, 8'h80);
    rd_chk(8'h10, 8'h00);
  endtask : t_mask
  task automatic t_bpv();
    restart(3'h5);
    play('{11'h400, 11'h400, 11'h500, 11'h200, 11'h200});
    rd_chk(8'h01, 8'h00);
    wait_flag(SHORT_N);
    rd_chk(8'h01, 8'h02);
    wait_flag(SHORT_N);
    rd_chk(8'h01, 8'h00);
    restart(3'h4);
    play('{11'h400, 11'h500});
    wait_flag(SHORT_N);
    rd_chk(8'h01, 8'h01);
  endtask : t_bpv
  task automatic t_cv();
    restart(3'h6);
    play('{11'h400, 11'h400, 11'h400, 11'h200, 11'h200});
    wait_flag(SHORT_N);
    rd_chk(8'h01, 8'h01);
  endtask : t_cv
  task automatic t_sync();
    restart(3'h4);
    play('{11'h080, 11'h082, 11'h084, 11'h081, 11'h040, 11'h042, 11'h041, 11'h060,
      11'h010, 11'h018, 11'h012, 11'h014, 11'h010, 11'h408, 11'h408});
    wait_flag(SHORT_N);
    read_six(48'h000100020802);
  endtask : t_sync
  task automatic t_sat();
    restart(3'h0);
    ev = 7'h4D;
    repeat (65540) @(negedge i_clock);
    ev = '0;
    wait_flag(LONG_N);
    read_six(48'hFFFFFFFFFFFF);
  endtask : t_sat
  initial begin
    err_count = 0;
    checked = 0;
    ev = '0;
    sy = '0;
    t_mask();
    t_bpv();
    t_cv();
    t_sync();
    t_sat();
    tally_and_finish();
  end
endmodule : tb
